/* dps_pkg.sv */
// constants for the dual-port synchronous sram port logic
package dps_pkg;
  localparam int NPORT = 2;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 9;
  localparam int DEPTH = 131072;
  // axi4-lite register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CNT0 = 8'h08;
  localparam logic [7:0] REG_CNT1 = 8'h0c;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [ADDR_W-1:0] CNT_RESET = 17'h00000;
endpackage : dps_pkg

/* dps_sram_ports.sv */
// dual-port synchronous sram: array, burst counters, output stages, axi4-lite status
module dps_sram_ports
  import dps_pkg::*;
(
  clock,
  rst_b,
  port_addr,
  address_load_strobe_n,
  count_advance_n,
  counter_clear_n,
  chip_select_low_active,
  chip_select_high_active,
  latency_select,
  read_not_write,
  output_enable_n,
  data_in,
  data_out,
  data_oe_n,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready
);
  input wire logic clock;
  input wire logic rst_b;
  input wire logic [NPORT-1:0][ADDR_W-1:0] port_addr;
  input wire logic [NPORT-1:0] address_load_strobe_n;
  input wire logic [NPORT-1:0] count_advance_n;
  input wire logic [NPORT-1:0] counter_clear_n;
  input wire logic [NPORT-1:0] chip_select_low_active;
  input wire logic [NPORT-1:0] chip_select_high_active;
  input wire logic [NPORT-1:0] latency_select;
  input wire logic [NPORT-1:0] read_not_write;
  input wire logic [NPORT-1:0] output_enable_n;
  input wire logic [NPORT-1:0][DATA_W-1:0] data_in;
  output logic [NPORT-1:0][DATA_W-1:0] data_out;
  output logic [NPORT-1:0] data_oe_n;
  input wire logic [7:0] s_axi_awaddr;
  input wire logic s_axi_awvalid;
  output logic s_axi_awready;
  input wire logic [31:0] s_axi_wdata;
  input wire logic [3:0] s_axi_wstrb;
  input wire logic s_axi_wvalid;
  output logic s_axi_wready;
  output logic [1:0] s_axi_bresp;
  output logic s_axi_bvalid;
  input wire logic s_axi_bready;
  input wire logic [7:0] s_axi_araddr;
  input wire logic s_axi_arvalid;
  output logic s_axi_arready;
  output logic [31:0] s_axi_rdata;
  output logic [1:0] s_axi_rresp;
  output logic s_axi_rvalid;
  input wire logic s_axi_rready;

  // ======================================================================
  // array
  // no reset on the array: contents are undefined at power-up
  logic [DATA_W-1:0] mem [0:DEPTH-1];
  logic [NPORT-1:0] sel;
  logic [NPORT-1:0] wr_en;
  logic [NPORT-1:0] rd_en;
  logic [NPORT-1:0][ADDR_W-1:0] acc_addr;
  logic [NPORT-1:0][ADDR_W-1:0] cnt_q;
  logic [NPORT-1:0][DATA_W-1:0] rd_q;
  logic [NPORT-1:0] rd_valid_q;
  logic [1:0] wprot_q;
  logic [NPORT-1:0] last_wr_q;

  // both ports write in one process; on a same-address collision port 1 lands last
  // single-edge write strobe, so no dependence on the clock high phase
  always_ff @(posedge clock) begin
    for (int p = 0; p < NPORT; p++) begin
      if (wr_en[p]) begin
        mem[acc_addr[p]] <= data_in[p];
      end
    end
  end

  // ======================================================================
  // per-port logic
  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_port
      assign sel[g] = !chip_select_low_active[g] && chip_select_high_active[g];
      assign wr_en[g] = sel[g] && !read_not_write[g] && !wprot_q[g];
      assign rd_en[g] = sel[g] && read_not_write[g];

      // access address: clear beats load, load beats advance, else hold
      always_comb begin
        if (!counter_clear_n[g]) begin
          acc_addr[g] = CNT_RESET;
        end else if (!address_load_strobe_n[g]) begin
          acc_addr[g] = port_addr[g];
        end else if (!count_advance_n[g]) begin
          acc_addr[g] = cnt_q[g] + ADDR_W'(1);
        end else begin
          acc_addr[g] = cnt_q[g];
        end
      end

      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          cnt_q[g] <= CNT_RESET;
        end else if (sel[g]) begin
          cnt_q[g] <= acc_addr[g];
        end
      end

      // array read stage feeds the pipelined output
      always_ff @(posedge clock) begin
        rd_q[g] <= mem[acc_addr[g]];
      end

      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          rd_valid_q[g] <= 1'b0;
          last_wr_q[g] <= 1'b0;
        end else begin
          rd_valid_q[g] <= rd_en[g];
          if (sel[g]) begin
            last_wr_q[g] <= !read_not_write[g];
          end
        end
      end

      // output stage: pipelined takes the read register, flow-through the array
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          data_out[g] <= '0;
          data_oe_n[g] <= 1'b1;
        end else if (latency_select[g]) begin
          data_out[g] <= rd_q[g];
          data_oe_n[g] <= !(rd_valid_q[g] && sel[g] && !output_enable_n[g]);
        end else begin
          data_out[g] <= mem[acc_addr[g]];
          data_oe_n[g] <= !(rd_en[g] && !output_enable_n[g]);
        end
      end

      // ------------------------------------------------------------------
      // checks
      a_clear_zero: assert property (@(posedge clock) disable iff (!rst_b)
        sel[g] && !counter_clear_n[g] |=> cnt_q[g] == CNT_RESET)
        else $error("counter not cleared");
      a_load_pins: assert property (@(posedge clock) disable iff (!rst_b)
        sel[g] && counter_clear_n[g] && !address_load_strobe_n[g]
        |=> cnt_q[g] == $past(port_addr[g]))
        else $error("counter not loaded from pins");
      a_count_step: assert property (@(posedge clock) disable iff (!rst_b)
        sel[g] && counter_clear_n[g] && address_load_strobe_n[g] && !count_advance_n[g]
        |=> cnt_q[g] == $past(cnt_q[g]) + ADDR_W'(1))
        else $error("counter did not advance");
      a_burst_two: assert property (@(posedge clock) disable iff (!rst_b)
        (sel[g] && counter_clear_n[g] && address_load_strobe_n[g] && !count_advance_n[g])[*2]
        |=> cnt_q[g] == $past(cnt_q[g], 2) + ADDR_W'(2))
        else $error("burst skipped a word");
      a_desel_hold: assert property (@(posedge clock) disable iff (!rst_b)
        !sel[g] |=> $stable(cnt_q[g]) && data_oe_n[g])
        else $error("deselected port changed state");
      a_pipe_wake: assert property (@(posedge clock) disable iff (!rst_b)
        latency_select[g] && sel[g] && !$past(sel[g]) |=> data_oe_n[g])
        else $error("pipelined output woke too early");
      // case equality: never-written words read back unknown from both stages
      a_flow_drive: assert property (@(posedge clock) disable iff (!rst_b)
        !latency_select[g] && rd_en[g] && !output_enable_n[g]
        |=> !data_oe_n[g] && data_out[g] === rd_q[g])
        else $error("flow-through data missing");
      a_pipe_drive: assert property (@(posedge clock) disable iff (!rst_b)
        rd_en[g] ##1 (latency_select[g] && sel[g] && !output_enable_n[g])
        |=> !data_oe_n[g] && data_out[g] === $past(rd_q[g]))
        else $error("pipelined data missing");
      c_burst: cover property (@(posedge clock) disable iff (!rst_b)
        (sel[g] && rd_en[g] && !count_advance_n[g] && address_load_strobe_n[g])[*3]);
      c_pipe_read: cover property (@(posedge clock) disable iff (!rst_b)
        latency_select[g] && !data_oe_n[g]);
      c_wrap: cover property (@(posedge clock) disable iff (!rst_b)
        sel[g] && cnt_q[g] == '1 && acc_addr[g] == '0);
      c_clear: cover property (@(posedge clock) disable iff (!rst_b)
        sel[g] && !counter_clear_n[g]);
    end
  endgenerate

  c_both_write: cover property (@(posedge clock) disable iff (!rst_b)
    wr_en[0] && wr_en[1] && acc_addr[0] == acc_addr[1]);

  // ======================================================================
  // per-port counter, array and output checks
  for (genvar h = 0; h < NPORT; h++) begin : g_chk
    a_wrap_zero: assert property (@(posedge clock) disable iff (!rst_b)
      sel[h] && counter_clear_n[h] && address_load_strobe_n[h] && !count_advance_n[h]
      && cnt_q[h] == '1 |=> cnt_q[h] == '0)
      else $error("counter did not wrap to zero");

    a_hold_count: assert property (@(posedge clock) disable iff (!rst_b)
      sel[h] && counter_clear_n[h] && address_load_strobe_n[h] && count_advance_n[h]
      |=> $stable(cnt_q[h]))
      else $error("idle counter moved");

    a_load_first: assert property (@(posedge clock) disable iff (!rst_b)
      sel[h] && counter_clear_n[h] && !address_load_strobe_n[h] && !count_advance_n[h]
      |=> cnt_q[h] == $past(port_addr[h]))
      else $error("advance overrode load");

    a_clear_first: assert property (@(posedge clock) disable iff (!rst_b)
      sel[h] && !counter_clear_n[h] && !(address_load_strobe_n[h] && count_advance_n[h])
      |=> cnt_q[h] == CNT_RESET)
      else $error("clear lost to load or advance");

    // on a same-address write from the other port in the same cycle, port 1's word lands last
    a_write_lands: assert property (@(posedge clock) disable iff (!rst_b)
      wr_en[h] && !(wr_en[1-h] && acc_addr[1-h] == acc_addr[h])
      |=> mem[$past(acc_addr[h])] == $past(data_in[h]))
      else $error("write did not land");

    a_desel_keep: assert property (@(posedge clock) disable iff (!rst_b)
      !sel[h] && !wr_en[1-h]
      |=> mem[$past(acc_addr[h])] === $past(mem[acc_addr[h]]))
      else $error("deselected port wrote the array");

    a_write_quiet: assert property (@(posedge clock) disable iff (!rst_b)
      !latency_select[h] && sel[h] && !read_not_write[h] |=> data_oe_n[h])
      else $error("flow-through port drove during a write");

    a_pipe_late: assert property (@(posedge clock) disable iff (!rst_b)
      latency_select[h] && rd_en[h] && !$past(rd_en[h]) |=> data_oe_n[h])
      else $error("pipelined data came a cycle early");

    a_pipe_desel: assert property (@(posedge clock) disable iff (!rst_b)
      latency_select[h] && !sel[h] |=> data_oe_n[h] ##1 data_oe_n[h])
      else $error("pipelined output woke without a selected cycle");

    // same-cycle writes return the old word; left out to keep the check simple
    a_flow_word: assert property (@(posedge clock) disable iff (!rst_b)
      !latency_select[h] && rd_en[h] && !wr_en[0] && !wr_en[1]
      |=> data_out[h] === $past(mem[acc_addr[h]]))
      else $error("flow-through word differs from the array");

    a_pipe_word: assert property (@(posedge clock) disable iff (!rst_b)
      latency_select[h] && rd_en[h] && !wr_en[0] && !wr_en[1] ##1 latency_select[h]
      |=> data_out[h] === $past(mem[acc_addr[h]], 2))
      else $error("pipelined word differs from the array");

    a_rd_track: assert property (@(posedge clock) disable iff (!rst_b)
      sel[h] |=> rd_valid_q[h] == $past(read_not_write[h]))
      else $error("read stage flag wrong");
  end

  // ======================================================================
  // axi4-lite write channel
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (s_axi_bvalid) begin
      if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // write-protect bits gate each port's array writes
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wprot_q <= CTRL_RESET;
    end else if (wr_fire && awaddr_q == REG_CTRL && wstrb_q[0]) begin
      wprot_q <= wdata_q[1:0];
    end
  end

  // ======================================================================
  // axi4-lite read channel
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        REG_CTRL: s_axi_rdata <= {30'h00000000, wprot_q};
        REG_STATUS: s_axi_rdata <= {26'h0000000, last_wr_q, rd_valid_q, sel};
        REG_CNT0: s_axi_rdata <= {15'h0000, cnt_q[0]};
        REG_CNT1: s_axi_rdata <= {15'h0000, cnt_q[1]};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
  end

  a_bvalid_hold: assert property (@(posedge clock) disable iff (!rst_b)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

endmodule // dps_sram_ports

/* dps_host.sv */
// host model that drives both memory ports of the dual-port ram
module dps_host
  import dps_pkg::*;
(
  input wire logic clock,
  output logic [NPORT-1:0][ADDR_W-1:0] port_addr,
  output logic [NPORT-1:0] address_load_strobe_n,
  output logic [NPORT-1:0] count_advance_n,
  output logic [NPORT-1:0] counter_clear_n,
  output logic [NPORT-1:0] chip_select_low_active,
  output logic [NPORT-1:0] chip_select_high_active,
  output logic [NPORT-1:0] latency_select,
  output logic [NPORT-1:0] read_not_write,
  output logic [NPORT-1:0] output_enable_n,
  output logic [NPORT-1:0][DATA_W-1:0] data_in,
  input wire logic [NPORT-1:0][DATA_W-1:0] data_out,
  input wire logic [NPORT-1:0] data_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // idle state
  initial begin
    port_addr = '0;
    data_in = '0;
    {address_load_strobe_n, count_advance_n, counter_clear_n} = '1;
    {chip_select_low_active, chip_select_high_active} = 4'h3;
    latency_select = 2'h2;
    read_not_write = 2'h3;
    output_enable_n = 2'h0;
  end
  // ====
  // one access of rep cycles; later cycles advance the counter
  // hosts never write one address in the same cycle; port 1's word would land last
  task automatic op(input int p, input logic [1:0] cs, input logic rnw, ld, adv, clr,
                    input logic [16:0] a, input logic [8:0] d, input int rep,
                    output logic [8:0] q, output logic oe);
    @(posedge clock);
    for (int i = 0; i < rep; i++) begin
      {chip_select_low_active[p], chip_select_high_active[p]} <= cs;
      read_not_write[p] <= rnw;
      address_load_strobe_n[p] <= (i == 0) ? ld : 1'b1;
      count_advance_n[p] <= (i == 0) ? adv : 1'b0;
      counter_clear_n[p] <= clr;
      port_addr[p] <= a;
      data_in[p] <= rnw ? ~d : d + 9'(i);
      @(posedge clock);
    end
    // idle is a selected read of the counter, so it never moves the counter
    {chip_select_low_active[p], chip_select_high_active[p]} <= 2'b01;
    read_not_write[p] <= 1'b1;
    {address_load_strobe_n[p], count_advance_n[p], counter_clear_n[p]} <= 3'h7;
    port_addr[p] <= ~a;
    data_in[p] <= ~data_in[p];
    if (latency_select[p]) @(posedge clock);
    #1;
    q = data_out[p];
    oe = data_oe_n[p];
  endtask
endmodule // dps_host

/* test_dual_port_sync_sram_ports.sv */
// self-checking bench for the dual-port sram port logic
module test_dual_port_sync_sram_ports
  import dps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [NPORT-1:0][ADDR_W-1:0] port_addr;
  logic [NPORT-1:0] address_load_strobe_n, count_advance_n, counter_clear_n;
  logic [NPORT-1:0] chip_select_low_active, chip_select_high_active, latency_select;
  logic [NPORT-1:0] read_not_write, output_enable_n, data_oe_n;
  logic [NPORT-1:0][DATA_W-1:0] data_in, data_out;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int err_total = 0;
  int comparisons = 0;
  dps_sram_ports u_dut (.clock, .rst_b, .port_addr, .address_load_strobe_n, .count_advance_n,
    .counter_clear_n, .chip_select_low_active, .chip_select_high_active, .latency_select,
    .read_not_write, .output_enable_n, .data_in, .data_out, .data_oe_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  dps_host u_host (.clock, .port_addr, .address_load_strobe_n, .count_advance_n,
    .counter_clear_n, .chip_select_low_active, .chip_select_high_active, .latency_select,
    .read_not_write, .output_enable_n, .data_in, .data_out, .data_oe_n);
  initial begin
    forever #5 clock = ~clock;
  end
  // ====
  // checks and bus tasks
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one transfer, write or read; the bound stands in for a hung slave
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    int n = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
    {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
    do begin
      @(posedge clock);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(wr ? s_axi_bvalid : s_axi_rvalid) && n < 50);
    q = s_axi_rdata;
    r = wr ? s_axi_bresp : s_axi_rresp;
    {s_axi_bready, s_axi_rready} <= 2'b00;
    if (n >= 50) begin
      err_total++;
      test_done();
    end
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0] r;
    axi(1'b0, a, 32'h0, q, r);
    chk("rdata", e, q);
    chk("rresp", 32'(er), 32'(r));
  endtask
  task automatic acc(input int p, input logic [1:0] cs, input logic rnw, ld, adv, clr,
                     input logic [16:0] a, input logic [8:0] d, input int rep,
                     input logic [8:0] e, input logic eoe);
    logic [8:0] q;
    logic oe;
    u_host.op(p, cs, rnw, ld, adv, clr, a, d, rep, q, oe);
    if (rnw) chk("data_oe_n", 32'(eoe), 32'(oe));
    if (rnw && !eoe) chk("data_out", 32'(e), 32'(q));
  endtask
  // ====
  // main sequence: port 0 flow-through, port 1 pipelined
  initial begin
    logic [31:0] q;
    logic [1:0] r;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    reg_rd(REG_CNT1, 32'(CNT_RESET), RESP_OKAY);
    reg_rd(8'h10, 32'h0, RESP_SLVERR);
    axi(1'b1, 8'h14, 32'h0, q, r);
    chk("bresp", 32'(RESP_SLVERR), 32'(r));
    acc(0, 2'b01, 0, 0, 1, 1, 17'h1fffe, 9'h1a0, 4, 9'h0, 0);
    reg_rd(REG_CNT0, 32'h1, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      acc(1, 2'b01, 1, 0, 1, 1, 17'h1fffe + 17'(i), 9'h0, 1, 9'h1a0 + 9'(i), 0);
      acc(0, 2'b01, 1, 0, 1, 1, 17'h1fffe + 17'(i), 9'h0, 1, 9'h1a0 + 9'(i), 0);
    end
    acc(0, 2'b01, 1, 0, 0, 0, 17'h1ffff, 9'h0, 1, 9'h1a2, 0);
    reg_rd(REG_CNT0, 32'h0, RESP_OKAY);
    acc(0, 2'b01, 1, 0, 0, 1, 17'h00000, 9'h0, 1, 9'h1a2, 0);
    acc(0, 2'b01, 1, 1, 0, 1, 17'h1fffe, 9'h0, 1, 9'h1a3, 0);
    // both ways of deselecting: low-active high, then high-active low
    for (int k = 0; k < 2; k++) begin
      acc(0, k ? 2'b00 : 2'b11, 0, 0, 1, 1, 17'h0, 9'h055, 1, 9'h0, 1);
      acc(0, k ? 2'b00 : 2'b11, 1, 0, 1, 1, 17'h0, 9'h0, 1, 9'h0, 1);
      acc(1, k ? 2'b00 : 2'b11, 1, 0, 1, 1, 17'h0, 9'h0, 1, 9'h0, 1);
    end
    reg_rd(REG_CNT0, 32'h1, RESP_OKAY);
    acc(0, 2'b01, 1, 0, 1, 1, 17'h0, 9'h0, 1, 9'h1a2, 0);
    axi(1'b1, REG_CTRL, 32'h1, q, r);
    chk("bresp", 32'(RESP_OKAY), 32'(r));
    reg_rd(REG_CTRL, 32'h1, RESP_OKAY);
    acc(0, 2'b01, 0, 0, 1, 1, 17'h1, 9'h0ff, 1, 9'h0, 0);
    acc(1, 2'b01, 0, 0, 1, 1, 17'h2, 9'h0cc, 1, 9'h0, 0);
    acc(0, 2'b01, 1, 0, 1, 1, 17'h1, 9'h0, 1, 9'h1a3, 0);
    acc(0, 2'b01, 1, 0, 1, 1, 17'h2, 9'h0, 1, 9'h0cc, 0);
    axi(1'b1, REG_CTRL, 32'h0, q, r);
    fork
      acc(0, 2'b01, 0, 0, 1, 1, 17'h3, 9'h133, 1, 9'h0, 0);
      acc(1, 2'b01, 0, 0, 1, 1, 17'h4, 9'h144, 1, 9'h0, 0);
    join
    fork
      acc(0, 2'b01, 1, 0, 1, 1, 17'h4, 9'h0, 1, 9'h144, 0);
      acc(1, 2'b01, 1, 0, 1, 1, 17'h3, 9'h0, 1, 9'h133, 0);
    join
    s_axi_wstrb <= 4'he;
    axi(1'b1, REG_CTRL, 32'h3, q, r);
    s_axi_wstrb <= 4'hf;
    reg_rd(REG_CTRL, 32'h0, RESP_OKAY);
    reg_rd(REG_STATUS, 32'h0000000f, RESP_OKAY);
    test_done();
  end
endmodule // test_dual_port_sync_sram_ports
